// >>> output_select_hibernate_ctrl.v
// output select and hibernate control register with burst pointer
// assumes a host interface that hands in decoded byte writes and reads
// assumes asynchronous pins and a sample tick on this clock
// Behaviour
// - magnitude disabled: no compute, bytes skipped
// - magnitude enabled: compute each sample, included
// - magnitude feeds change detection in mode 1
// - axis skip bit excludes axis from burst
// - grounded boot pin: hibernate bit one enters hibernate, clears registers
// - grounded boot pin: wake on chip-select toggle
// - boot pin high: motion pin high wakes active
// - boot pin high: motion pin low hibernates
`timescale 1ns/10ps
`default_nettype none
`include "output_select_hibernate_ctrl_consts.vh"
module output_select_hibernate_ctrl #(
    parameter W = 12
) (
    input wire I_MCLK,
    input wire I_SRST,
    input wire [7:0] I_WR_ADDR,
    input wire [7:0] I_WR_DATA,
    input wire I_WR_EN,
    input wire [7:0] I_RD_ADDR,
    output reg [7:0] O_RD_DATA,
    input wire [7:0] I_BURST_ADDR,
    output reg [7:0] O_BURST_NEXT,
    input wire I_ODR_TICK,
    input wire [W-1:0] I_X,
    input wire [W-1:0] I_Y,
    input wire [W-1:0] I_Z,
    input wire I_CD_MODE_MAG,
    output wire [W-1:0] O_CD_MAG,
    output wire O_CD_MAG_VALID,
    output reg [W-1:0] O_MAG,
    output wire O_MAG_VALID,
    input wire I_BOOT_CONFIG_PIN,
    input wire I_MOTION_DETECT_PIN,
    input wire I_CS_WAKE_PIN,
    output reg O_HIBERNATE,
    output reg O_MOTION_ACTIVE,
    output reg O_REG_CLEAR
);
    // three-stage synchronisers for the pins
    reg [2:0] boot_s_r;
    reg [2:0] mot_s_r;
    reg [2:0] cs_s_r;
    reg boot_r; // filtered boot pin level
    reg mot_r; // filtered motion pin level
    reg cs_r; // filtered chip-select level
    reg [7:0] cfg_r; // the configuration register
    reg cs_at_sleep_r; // chip-select level caught at hibernate entry by command
    // next register value, from a host write
    reg [7:0] cfg_nxt;
    // magnitude engine hookup
    wire mag_en = cfg_r[`OSS_BIT_MAG_EN];
    wire mag_done;
    wire [W-1:0] mag_val;

    // pins pass three flops; change taken when stages two and three agree
    always @(posedge I_MCLK) begin
        if (I_SRST) begin
            boot_s_r <= 3'h0;
            mot_s_r <= 3'h0;
            // chip-select idles high, so its stages start high
            cs_s_r <= 3'h7;
            boot_r <= 1'b0;
            mot_r <= 1'b0;
            cs_r <= 1'b1;
        end else begin
            // shift the pins in on every edge
            boot_s_r <= {boot_s_r[1:0], I_BOOT_CONFIG_PIN};
            mot_s_r <= {mot_s_r[1:0], I_MOTION_DETECT_PIN};
            cs_s_r <= {cs_s_r[1:0], I_CS_WAKE_PIN};
            // stage two and three agree: accept the level
            if (boot_s_r[1] == boot_s_r[2]) begin
                boot_r <= boot_s_r[2];
            end
            if (mot_s_r[1] == mot_s_r[2]) begin
                mot_r <= mot_s_r[2];
            end
            if (cs_s_r[1] == cs_s_r[2]) begin
                cs_r <= cs_s_r[2];
            end
        end
    end

    // next value of the configuration register
    always @* begin
        cfg_nxt = cfg_r;
        if (I_WR_EN && (I_WR_ADDR == `OSS_REG_ADDR)) begin
            // unused upper bits always read back zero
            cfg_nxt = I_WR_DATA & `OSS_WMASK;
        end
    end

    // register, hibernate state and volatile clear
    always @(posedge I_MCLK) begin
        if (I_SRST) begin
            cfg_r <= `OSS_RESET_VAL;
            O_HIBERNATE <= 1'b0;
            O_MOTION_ACTIVE <= 1'b0;
            O_REG_CLEAR <= 1'b0;
            cs_at_sleep_r <= 1'b1;
        end else begin
            // clear pulse lasts one cycle unless set again below
            O_REG_CLEAR <= 1'b0;
            if (boot_r) begin
                // motion pin level drives hibernate directly
                if (!mot_r) begin
                    O_HIBERNATE <= 1'b1;
                    O_MOTION_ACTIVE <= 1'b0;
                    O_REG_CLEAR <= !O_HIBERNATE;
                    cfg_r <= `OSS_RESET_VAL;
                end else begin
                    // motion high: straight to active, settings kept
                    O_HIBERNATE <= 1'b0;
                    O_MOTION_ACTIVE <= 1'b1;
                    cfg_r <= cfg_nxt;
                end
            end else if (O_HIBERNATE) begin
                // shut down; only a chip-select toggle wakes
                O_MOTION_ACTIVE <= 1'b0;
                if (cs_r != cs_at_sleep_r) begin
                    O_HIBERNATE <= 1'b0;
                end
            end else if (cfg_nxt[`OSS_BIT_HIBERNATE]) begin
                // hibernate command: lose contents, remember cs level
                O_HIBERNATE <= 1'b1;
                O_REG_CLEAR <= 1'b1;
                cfg_r <= `OSS_RESET_VAL;
                // waking later needs the opposite level of this one
                cs_at_sleep_r <= cs_r;
                O_MOTION_ACTIVE <= 1'b0;
            end else begin
                // awake: host writes land
                O_MOTION_ACTIVE <= 1'b0;
                cfg_r <= cfg_nxt;
            end
        end
    end

    // magnitude computed only while enabled and awake
    // gating the start keeps the engine idle while off or asleep
    vector_magnitude #(
        .W(W)
    ) u_mag (
        .I_MCLK(I_MCLK),
        .I_SRST(I_SRST),
        .i_start(I_ODR_TICK && mag_en && !O_HIBERNATE),
        .i_x(I_X),
        .i_y(I_Y),
        .i_z(I_Z),
        .o_mag(mag_val),
        .o_done(mag_done)
    );

    // magnitude output: the engine's result flop drives the port, so
    // the value is new in the very cycle that the valid pulse stands;
    // a second hold flop would leave the pulse one cycle ahead
    always @* begin
        O_MAG = mag_val;
    end
    // valid pulse follows the engine's done flop
    assign O_MAG_VALID = mag_done;
    // change detection sees magnitude when its mode selects it
    assign O_CD_MAG = I_CD_MODE_MAG ? O_MAG : {W{1'b0}};
    assign O_CD_MAG_VALID = I_CD_MODE_MAG & mag_done;

    // true when an output register address is in the burst range
    function incl;
        input [7:0] a;
        input [7:0] c;
        begin
            if (a == `OUT_X_LSB || a == `OUT_X_MSB) begin
                incl = !c[`OSS_BIT_X_SKIP];
            end else if (a == `OUT_Y_LSB || a == `OUT_Y_MSB) begin
                incl = !c[`OSS_BIT_Y_SKIP];
            end else if (a == `OUT_Z_LSB || a == `OUT_Z_MSB) begin
                incl = !c[`OSS_BIT_Z_SKIP];
            end else if (a == `OUT_MAG_LSB || a == `OUT_MAG_MSB) begin
                incl = c[`OSS_BIT_MAG_EN];
            end else begin
                // bytes outside the output block always count
                incl = 1'b1;
            end
        end
    endfunction

    // next burst address: step, then hop over excluded bytes
    // eight hops cover the longest run of skipped bytes
    // and a hop never passes the address after the last output
    reg [7:0] step;
    integer k;
    always @* begin
        step = I_BURST_ADDR + 8'h01;
        for (k = 0; k < 8; k = k + 1) begin
            if (!incl(step, cfg_r)) begin
                step = step + 8'h01;
            end
        end
    end

    // registered read data and burst pointer
    always @(posedge I_MCLK) begin
        if (I_SRST) begin
            O_RD_DATA <= 8'h00;
            O_BURST_NEXT <= 8'h00;
        end else begin
            // pointer offered every cycle; host takes it as it steps
            O_BURST_NEXT <= step;
            // only this register answers; other addresses read zero
            if (I_RD_ADDR == `OSS_REG_ADDR) begin
                O_RD_DATA <= cfg_r;
            end else begin
                O_RD_DATA <= 8'h00;
            end
        end
    end
endmodule // output_select_hibernate_ctrl
`default_nettype wire

// >>> output_select_hibernate_ctrl_consts.vh
// constants for the output select and hibernate control block
// assumes inclusion by bare name from design files of this block
`ifndef OUTPUT_SELECT_HIBERNATE_CTRL_CONSTS_VH
`define OUTPUT_SELECT_HIBERNATE_CTRL_CONSTS_VH
`define OSS_REG_ADDR 8'h19
`define OSS_RESET_VAL 8'h00
`define OSS_BIT_MAG_EN 4
`define OSS_BIT_X_SKIP 3
`define OSS_BIT_Y_SKIP 2
`define OSS_BIT_Z_SKIP 1
`define OSS_BIT_HIBERNATE 0
`define OSS_WMASK 8'h1f
// output register addresses walked by a burst read
`define OUT_X_LSB 8'h04
`define OUT_X_MSB 8'h05
`define OUT_Y_LSB 8'h06
`define OUT_Y_MSB 8'h07
`define OUT_Z_LSB 8'h08
`define OUT_Z_MSB 8'h09
`define OUT_MAG_LSB 8'h0a
`define OUT_MAG_MSB 8'h0b
`define OUT_AFTER_LAST 8'h0c
`endif

// >>> vector_magnitude.v
// vector magnitude engine: |v| approximated as max + 3/8 of the rest
// assumes signed 12-bit axis samples and a one-cycle start pulse
`timescale 1ns/10ps
`default_nettype none
module vector_magnitude #(
    parameter W = 12
) (
    input wire I_MCLK,
    input wire I_SRST,
    input wire i_start,
    input wire [W-1:0] i_x,
    input wire [W-1:0] i_y,
    input wire [W-1:0] i_z,
    output reg [W-1:0] o_mag,
    output reg o_done
);
    // absolute value of a signed sample
    function [W-1:0] absval;
        input [W-1:0] v;
        begin
            absval = v[W-1] ? (~v + {{(W-1){1'b0}}, 1'b1}) : v;
        end
    endfunction
    wire [W-1:0] ax = absval(i_x);
    wire [W-1:0] ay = absval(i_y);
    wire [W-1:0] az = absval(i_z);
    wire [W-1:0] mxy = (ax > ay) ? ax : ay;
    wire [W-1:0] mx = (mxy > az) ? mxy : az;
    // sum of all three minus the max, widened against overflow
    wire [W+1:0] sum = {2'b00, ax} + {2'b00, ay} + {2'b00, az};
    wire [W+1:0] rest = sum - {2'b00, mx};
    // three times the rest, then an exact cut of the low three bits
    wire [W+3:0] trip = {1'b0, rest, 1'b0} + {2'b00, rest};
    wire [W+2:0] part = {2'b00, trip[W+3:3]};
    wire [W+2:0] tot = {3'b000, mx} + part;
    // register result, saturate at full scale
    always @(posedge I_MCLK) begin
        if (I_SRST) begin
            o_mag <= {W{1'b0}};
            o_done <= 1'b0;
        end else begin
            o_done <= i_start;
            if (i_start) begin
                o_mag <= (|tot[W+2:W]) ? {W{1'b1}} : tot[W-1:0];
            end
        end
    end
endmodule // vector_magnitude
`default_nettype wire

// >>> osh_asserts.sv
// checker for the output select and hibernate block
// assumes pins stay put for eight cycles after a change
`timescale 1ns/10ps
`default_nettype none
module osh_asserts #(
    parameter W = 12
) (
    input wire I_MCLK,
    input wire I_SRST,
    input wire [7:0] I_WR_ADDR,
    input wire [7:0] I_WR_DATA,
    input wire I_WR_EN,
    input wire [7:0] I_BURST_ADDR,
    input wire [7:0] O_BURST_NEXT,
    input wire I_ODR_TICK,
    input wire I_CD_MODE_MAG,
    input wire [W-1:0] O_CD_MAG,
    input wire O_CD_MAG_VALID,
    input wire [W-1:0] O_MAG,
    input wire O_MAG_VALID,
    input wire I_BOOT_CONFIG_PIN,
    input wire I_MOTION_DETECT_PIN,
    input wire I_CS_WAKE_PIN,
    input wire O_HIBERNATE,
    input wire O_MOTION_ACTIVE,
    input wire O_REG_CLEAR
);
    // reset seen one edge ago; keeps checks off the release edge
    reg rst_q_r;
    always @(posedge I_MCLK) begin
        rst_q_r <= I_SRST;
    end
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_SRST || rst_q_r);
    mag_after_tick_a: assert property (
        O_MAG_VALID |-> $past(I_ODR_TICK))
        else $error("magnitude valid without tick");
    cd_feed_a: assert property (
        O_CD_MAG_VALID == (I_CD_MODE_MAG && O_MAG_VALID)
        && O_CD_MAG == (I_CD_MODE_MAG ? O_MAG : {W{1'b0}}))
        else $error("cd feed");
    hib_write_a: assert property (
        I_WR_EN && I_WR_ADDR == 8'h19 && I_WR_DATA[0]
        && !O_HIBERNATE && !I_BOOT_CONFIG_PIN
        |=> O_HIBERNATE && O_REG_CLEAR)
        else $error("no hibernate entry");
    clear_pulse_a: assert property (O_REG_CLEAR |=> !O_REG_CLEAR)
        else $error("clear pulse too long");
    burst_hop_a: assert property (I_BURST_ADDR inside {[8'h04:8'h0b]} |=>
        O_BURST_NEXT > $past(I_BURST_ADDR) && O_BURST_NEXT <= 8'h0c)
        else $error("burst next out of range");
    cs_wake_a: assert property (O_HIBERNATE && !I_BOOT_CONFIG_PIN
        && $changed(I_CS_WAKE_PIN) |-> ##[1:8] !O_HIBERNATE) else $error("no wake");
    motion_low_a: assert property (I_BOOT_CONFIG_PIN
        && $fell(I_MOTION_DETECT_PIN) |-> ##[1:8] O_HIBERNATE) else $error("no sleep");
    motion_high_a: assert property (I_BOOT_CONFIG_PIN
        && $rose(I_MOTION_DETECT_PIN) |-> ##[1:8] O_MOTION_ACTIVE && !O_HIBERNATE)
        else $error("no motion wake");
    cover property (O_MAG_VALID);
    cover property ($fell(O_HIBERNATE));
    cover property (O_CD_MAG_VALID);
endmodule // osh_asserts
bind output_select_hibernate_ctrl osh_asserts #(.W(W)) i_osh_asserts (
    .I_MCLK(I_MCLK),
    .I_SRST(I_SRST),
    .I_WR_ADDR(I_WR_ADDR),
    .I_WR_DATA(I_WR_DATA),
    .I_WR_EN(I_WR_EN),
    .I_BURST_ADDR(I_BURST_ADDR),
    .O_BURST_NEXT(O_BURST_NEXT),
    .I_ODR_TICK(I_ODR_TICK),
    .I_CD_MODE_MAG(I_CD_MODE_MAG),
    .O_CD_MAG(O_CD_MAG),
    .O_CD_MAG_VALID(O_CD_MAG_VALID),
    .O_MAG(O_MAG),
    .O_MAG_VALID(O_MAG_VALID),
    .I_BOOT_CONFIG_PIN(I_BOOT_CONFIG_PIN),
    .I_MOTION_DETECT_PIN(I_MOTION_DETECT_PIN),
    .I_CS_WAKE_PIN(I_CS_WAKE_PIN),
    .O_HIBERNATE(O_HIBERNATE),
    .O_MOTION_ACTIVE(O_MOTION_ACTIVE),
    .O_REG_CLEAR(O_REG_CLEAR)
);
`default_nettype wire

// >>> osh_host.sv
// host model: flips the wake pin, then waits out boot
// assumes the bench pulses i_wake for one cycle
`timescale 1ns/10ps
`default_nettype none
module osh_host #(
    parameter BOOT1 = 16 // first boot interval in cycles
) (
    input wire logic i_clk,
    input wire logic i_wake,
    output logic o_cs,
    output logic o_ready
);
    int cnt_r = 0; // cycles left of the boot wait
    initial o_cs = 1'h1;
    initial o_ready = 1'h1;
    // toggle away from the held level, then hold off traffic
    always @(posedge i_clk) begin
        if (i_wake) begin
            o_cs <= ~o_cs;
            o_ready <= 1'h0;
            cnt_r <= BOOT1;
        end else if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
            o_ready <= (cnt_r == 1);
        end
    end
endmodule // osh_host
`default_nettype wire

// >>> output_select_hibernate_ctrl_test.sv
// bench for the output select and hibernate block
// assumes checker and host model are compiled first
`timescale 1ns/10ps
`default_nettype none
module output_select_hibernate_ctrl_test;
    logic I_MCLK, I_SRST, I_WR_EN, I_ODR_TICK, I_CD_MODE_MAG;
    logic I_BOOT_CONFIG_PIN, I_MOTION_DETECT_PIN, I_CS_WAKE_PIN;
    logic [7:0] I_WR_ADDR, I_WR_DATA, I_RD_ADDR, I_BURST_ADDR;
    logic [7:0] O_RD_DATA, O_BURST_NEXT, c;
    logic [11:0] I_X, I_Y, I_Z, O_CD_MAG, O_MAG;
    logic O_CD_MAG_VALID, O_MAG_VALID, O_HIBERNATE, O_MOTION_ACTIVE;
    logic O_REG_CLEAR, due, wake, rdy;
    logic [7:0] q[$]; // expected config reads
    int fails = 0;
    int check_count = 0;
    int clr_n = 0; // volatile clear pulses seen
    logic [11:0] mlast = 12'h0; // magnitude that O_MAG must hold
    output_select_hibernate_ctrl i_output_select_hibernate_ctrl (
        .I_MCLK(I_MCLK),
        .I_SRST(I_SRST),
        .I_WR_ADDR(I_WR_ADDR),
        .I_WR_DATA(I_WR_DATA),
        .I_WR_EN(I_WR_EN),
        .I_RD_ADDR(I_RD_ADDR),
        .O_RD_DATA(O_RD_DATA),
        .I_BURST_ADDR(I_BURST_ADDR),
        .O_BURST_NEXT(O_BURST_NEXT),
        .I_ODR_TICK(I_ODR_TICK),
        .I_X(I_X),
        .I_Y(I_Y),
        .I_Z(I_Z),
        .I_CD_MODE_MAG(I_CD_MODE_MAG),
        .O_CD_MAG(O_CD_MAG),
        .O_CD_MAG_VALID(O_CD_MAG_VALID),
        .O_MAG(O_MAG),
        .O_MAG_VALID(O_MAG_VALID),
        .I_BOOT_CONFIG_PIN(I_BOOT_CONFIG_PIN),
        .I_MOTION_DETECT_PIN(I_MOTION_DETECT_PIN),
        .I_CS_WAKE_PIN(I_CS_WAKE_PIN),
        .O_HIBERNATE(O_HIBERNATE),
        .O_MOTION_ACTIVE(O_MOTION_ACTIVE),
        .O_REG_CLEAR(O_REG_CLEAR)
    );
    osh_host i_osh_host (.i_clk(I_MCLK), .i_wake(wake), .o_cs(I_CS_WAKE_PIN),
        .o_ready(rdy));
    task chk(input logic [15:0] s, input logic [15:0] e);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("wrong value at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task close_out;
        $display("fails %0d checks %0d", fails, check_count);
        if (fails == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge I_MCLK);
    endtask
    // write the config, note what a read must return
    task wr(input logic [7:0] d, input logic [7:0] e);
        @(posedge I_MCLK);
        I_WR_DATA <= d;
        I_WR_EN <= 1'h1;
        q.push_back(e);
        @(posedge I_MCLK);
        I_WR_EN <= 1'h0;
        cyc(2);
        due <= 1'h1;
        @(posedge I_MCLK);
        due <= 1'h0;
    endtask
    // next included burst address from our own walk
    function logic [7:0] nxt(input logic [7:0] k, input logic [7:0] a);
        logic [7:0] b;
        b = a + 8'h01;
        while (b < 8'h0c && (b < 8'h0a ? k[3 - (b - 4) / 2] : !k[4]))
            b = b + 8'h01;
        return b;
    endfunction
    // absolute value of a signed 12-bit sample
    function automatic int mag_abs(input logic [11:0] v);
        return v[11] ? 4096 - int'(v) : int'(v);
    endfunction
    // magnitude model: largest axis plus three eighths of the others
    function automatic logic [11:0] mag_ref(input logic [11:0] x,
        input logic [11:0] y, input logic [11:0] z);
        int ax;
        int ay;
        int az;
        int mx;
        ax = mag_abs(x);
        ay = mag_abs(y);
        az = mag_abs(z);
        mx = (ax > ay) ? ax : ay;
        mx = (mx > az) ? mx : az;
        mx = mx + 3 * (ax + ay + az - mx) / 8;
        return (mx > 4095) ? 12'hfff : 12'(mx);
    endfunction
    // result watcher takes the oldest note
    always @(posedge I_MCLK) begin
        if (due === 1'h1) begin
            chk(O_RD_DATA, q.pop_front());
        end
    end
    // counts volatile clear pulses
    always @(posedge I_MCLK) begin
        if (O_REG_CLEAR === 1'h1) begin
            clr_n++;
        end
    end
    initial begin
        I_MCLK = 1'h0;
        forever #20 I_MCLK = ~I_MCLK;
    end
    initial begin
        cyc(5000);
        fails++;
        close_out;
    end
    initial begin
        {I_SRST, I_WR_EN, I_ODR_TICK, I_CD_MODE_MAG, due, wake} = 6'h20;
        {I_BOOT_CONFIG_PIN, I_MOTION_DETECT_PIN} = 2'h0;
        {I_WR_ADDR, I_RD_ADDR, I_WR_DATA, I_BURST_ADDR} = 32'h19190000;
        {I_X, I_Y, I_Z} = 36'h0;
        void'($urandom(80291));
        cyc(20);
        I_SRST <= 1'h0;
        cyc(4);
        // random settings: readback, burst walk, magnitude tick
        repeat (8) begin
            c = $urandom & 8'hfe;
            wr(c, c & 8'h1e);
            for (int a = 4; a < 12; a++) begin
                I_BURST_ADDR <= 8'(a);
                cyc(2);
                chk(O_BURST_NEXT, nxt(c, 8'(a)));
            end
            I_X <= 12'($urandom);
            I_Y <= 12'($urandom);
            I_Z <= 12'($urandom);
            I_CD_MODE_MAG <= 1'($urandom);
            I_ODR_TICK <= 1'h1;
            cyc(1);
            I_ODR_TICK <= 1'h0;
            if (c[4]) mlast = mag_ref(I_X, I_Y, I_Z);
            cyc(1);
            chk(O_MAG_VALID, c[4]);
            chk(O_MAG, mlast);
            chk(O_CD_MAG_VALID, I_CD_MODE_MAG & c[4]);
            chk(O_CD_MAG, I_CD_MODE_MAG ? mlast : 12'h0);
        end
        wr(8'h11, 8'h00);
        chk(O_HIBERNATE, 1'h1);
        chk(16'(clr_n), 16'h1);
        wake <= 1'h1;
        cyc(1);
        wake <= 1'h0;
        cyc(30);
        chk({O_HIBERNATE, rdy}, 2'h1);
        wr(8'h1e, 8'h1e);
        // boot pin high: motion pin rules the state
        {I_SRST, I_BOOT_CONFIG_PIN, I_MOTION_DETECT_PIN} <= 3'h7;
        cyc(4);
        I_SRST <= 1'h0;
        cyc(8);
        chk(O_MOTION_ACTIVE, 1'h1);
        I_MOTION_DETECT_PIN <= 1'h0;
        cyc(8);
        chk(O_HIBERNATE, 1'h1);
        chk(16'(clr_n), 16'h2);
        I_MOTION_DETECT_PIN <= 1'h1;
        cyc(8);
        chk({O_HIBERNATE, O_MOTION_ACTIVE}, 2'h1);
        close_out;
    end
endmodule // output_select_hibernate_ctrl_test
`default_nettype wire
